// ===== verilog/bspm_defines.svh
// Constants of the bar scan / peak measure sequencer: offsets, fields, counts.
// Assumes a 20 MHz clock and a byte-wide serial transmitter downstream.
`ifndef BSPM_DEFINES_SVH
`define BSPM_DEFINES_SVH

`define BSPM_ADDR_CMD     8'h00
`define BSPM_ADDR_INIT    8'h04
`define BSPM_ADDR_FINAL   8'h08
`define BSPM_ADDR_NF      8'h0c
`define BSPM_ADDR_DET     8'h10
`define BSPM_ADDR_PRESS   8'h14
`define BSPM_ADDR_POINTS  8'h18
`define BSPM_ADDR_STATUS  8'h1c

`define BSPM_CMD_OP_LSB   16
`define BSPM_CMD_OP_MSB   17
`define BSPM_CMD_ARG_MSB  15

`define BSPM_PRESSURE_ENABLE_FLAG_RST  1'b1
`define BSPM_CLK_MHZ      20
`define BSPM_SETTLE_US    100
`define BSPM_SETTLE_CYC   (`BSPM_SETTLE_US * `BSPM_CLK_MHZ)

`define BSPM_MASS_SCALE   13'h000a
`define BSPM_MINI_HALF    13'h0003
`define BSPM_MINI_LAST    3'h6

`endif

// ===== verilog/bspm_pkg.sv
// Types of the bar scan / peak measure sequencer.
// Assumes nothing beyond the defines header.
`default_nettype none
package bspm_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_BAR, OP_SINGLE, OP_ZERO} bspm_op_t;
  typedef enum logic [1:0] {MK_ZERO, MK_TUNE, MK_ION, MK_TP} bspm_meas_t;
  typedef enum logic [2:0] {
    S_IDLE, S_DRAIN, S_ZERO, S_TUNE, S_SETTLE, S_ION, S_TP, S_PUSH
  } bspm_state_t;
endpackage
`default_nettype wire

// ===== verilog/bspm_word_tx.sv
// Splits 32-bit words into bytes, least significant first.
// Assumes a byte sink with valid/ready on the same clock.
`default_nettype none
module bspm_word_tx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Word side
  input  wire logic [31:0] word,
  input  wire logic        wordValid,
  output logic             wordReady,
  input  wire logic        flush,
  output logic             idle,
  // Byte side
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady
);
  logic [31:0] word_r;
  logic [1:0]  idx_r;
  logic        busy_r;

  assign wordReady = !busy_r && !flush;
  assign idle      = !busy_r;
  assign txValid   = busy_r;
  assign txData    = word_r[7:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_r <= 32'h0000_0000;
      idx_r  <= 2'h0;
      busy_r <= 1'b0;
    end else if (flush) begin
      busy_r <= 1'b0;
      idx_r  <= 2'h0;
    end else if (!busy_r && wordValid) begin
      word_r <= word;
      busy_r <= 1'b1;
      idx_r  <= 2'h0;
    end else if (busy_r && txReady) begin
      word_r <= {8'h00, word_r[31:8]};
      idx_r  <= idx_r + 2'h1;
      if (idx_r == 2'h3)
        busy_r <= 1'b0;
    end
  end
endmodule // bspm_word_tx
`default_nettype wire

// ===== verilog/bspm_seq.sv
// Measurement sequencer: bar scans, single mass peak-lock, detector zero.
// Assumes a measurement engine with start/done handshake on this clock.
`include "bspm_defines.svh"
`default_nettype none
module bspm_seq
  import bspm_pkg::*;
#(
  parameter int MASS_W     = 9,
  parameter int DEPTH      = 512,
  parameter int SETTLE_CYC = `BSPM_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Measurement engine
  output logic             measStart,
  output logic             measAbort,
  output bspm_meas_t       measKind,
  output logic             measDet,
  output logic [2:0]       measNf,
  input  wire logic        measDone,
  input  wire logic [31:0] measValue,
  // Mass filter and detector
  output logic             rfOn,
  output logic [12:0]      rfMass,
  output logic             emOn,
  output logic [2:0]       noiseFloor,
  // Byte stream to the serial transmitter
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady
);
  localparam int AW = $clog2(DEPTH);

  bspm_state_t state_r;
  bspm_op_t    op_r;
  bspm_meas_t  kind_r;
  logic              issued_r;
  logic              start_r;
  logic              abort_r;
  logic [15:0]       scans_r;
  logic              cont_r;
  logic [MASS_W-1:0] mass_r;
  logic [2:0]        pt_r;
  logic [15:0]       settle_r;
  logic signed [31:0] max_r;
  logic [31:0]       push_r;
  logic              pushTp_r;
  logic              det_r;
  logic [2:0]        nf_r;
  logic [31:0]       offset_r [16];
  logic              rfOn_r;
  logic [12:0]       rfMass_r;
  logic [MASS_W-1:0] init_r;
  logic [MASS_W-1:0] final_r;
  logic [2:0]        nfSet_r;
  logic              emSet_r;
  logic              tpFlag_r;
  logic [31:0]       rdata_r;
  logic [31:0]       mem [DEPTH];
  logic [AW-1:0]     wrPtr_r;
  logic [AW-1:0]     rdPtr_r;
  logic [AW:0]       count_r;
  logic              busy;
  logic              cmdWr;
  bspm_op_t          cmdOp;
  logic [15:0]       cmdArg;
  logic              flush;
  logic              fifoEmpty;
  logic              fifoFull;
  logic              fifoPush;
  logic              fifoPop;
  logic              wordReady;
  logic              txIdle;
  logic [3:0]        offIdx;
  logic signed [31:0] corr;
  logic signed [31:0] newMax;
  logic [MASS_W-1:0] points;
  logic              scanMore;

  assign busy      = state_r != S_IDLE;
  assign cmdWr     = wr && addr == `BSPM_ADDR_CMD;
  assign cmdOp     = bspm_op_t'(wdata[`BSPM_CMD_OP_MSB:`BSPM_CMD_OP_LSB]);
  assign cmdArg    = wdata[`BSPM_CMD_ARG_MSB:0];
  assign flush     = cmdWr && busy;
  assign fifoEmpty = count_r == '0;
  assign fifoFull  = count_r == (AW+1)'(DEPTH);
  assign fifoPush  = state_r == S_PUSH && !fifoFull && !cmdWr;
  assign fifoPop   = !fifoEmpty && wordReady;
  assign offIdx    = {det_r, nf_r};
  // Stored zero offset corrects every reading taken under the same settings
  assign corr      = $signed(measValue) - $signed(offset_r[offIdx]);
  assign newMax    = (pt_r == 3'h0 || corr > max_r) ? corr : max_r;
  assign points    = (final_r >= init_r) ? final_r - init_r + 1'b1 : '0;
  assign scanMore  = cont_r || scans_r > 16'h0001;
  assign measStart  = start_r;
  assign measAbort  = abort_r;
  assign measKind   = kind_r;
  assign measDet    = det_r;
  assign measNf     = nf_r;
  assign rfOn       = rfOn_r;
  assign rfMass     = rfMass_r;
  assign emOn       = emSet_r;
  assign noiseFloor = nfSet_r;
  assign rdata      = rdata_r;

  // Settings registers; pressure enable is protected on multiplier turn-on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_r   <= '0;
      final_r  <= '0;
      nfSet_r  <= 3'h0;
      emSet_r  <= 1'b0;
      tpFlag_r <= `BSPM_PRESSURE_ENABLE_FLAG_RST;
    end else if (wr) begin
      unique case (addr)
        `BSPM_ADDR_INIT:  init_r  <= wdata[MASS_W-1:0];
        `BSPM_ADDR_FINAL: final_r <= wdata[MASS_W-1:0];
        `BSPM_ADDR_NF:    nfSet_r <= wdata[2:0];
        `BSPM_ADDR_DET: begin
          emSet_r <= wdata[0];
          if (wdata[0] && !emSet_r)
            tpFlag_r <= 1'b0;
        end
        `BSPM_ADDR_PRESS: tpFlag_r <= wdata[0];
        default: ;
      endcase
    end
  end
  // Read port, data stands in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (rd) begin
        unique case (addr)
          `BSPM_ADDR_CMD:    rdata_r <= {29'h0000_0000, state_r};
          `BSPM_ADDR_INIT:   rdata_r <= 32'(init_r);
          `BSPM_ADDR_FINAL:  rdata_r <= 32'(final_r);
          `BSPM_ADDR_NF:     rdata_r <= {29'h0000_0000, nfSet_r};
          `BSPM_ADDR_DET:    rdata_r <= {31'h0000_0000, emSet_r};
          `BSPM_ADDR_PRESS:  rdata_r <= {31'h0000_0000, tpFlag_r};
          `BSPM_ADDR_POINTS: rdata_r <= 32'(points);
          `BSPM_ADDR_STATUS: rdata_r <= {14'h0000, 3'(count_r >> AW),
                                         5'h00, rfOn_r, txIdle, 7'h00, busy};
          default: ;
        endcase
      end
    end
  end
  // Output buffer holds 512 words, one short of the widest scan; words leave when taken by the transmitter,
  // or all at once when a command write during a run flushes it
  always_ff @(posedge clk) begin
    if (fifoPush)
      mem[wrPtr_r] <= push_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (fifoPush)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (fifoPop)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (fifoPush && !fifoPop)
        count_r <= count_r + 1'b1;
      else if (fifoPop && !fifoPush)
        count_r <= count_r - 1'b1;
    end
  end
  bspm_word_tx u_tx (
    .clk       (clk),
    .nrst      (nrst),
    .word      (mem[rdPtr_r]),
    .wordValid (!fifoEmpty),
    .wordReady (wordReady),
    .flush     (flush),
    .idle      (txIdle),
    .txData    (txData),
    .txValid   (txValid),
    .txReady   (txReady)
  );
  // Zero offsets per detector setting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++)
        offset_r[i] <= 32'h0000_0000;
    end else if (!cmdWr && state_r == S_ZERO && issued_r && measDone) begin
      offset_r[offIdx] <= measValue;
    end
  end
  // Command sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= S_IDLE;
      op_r     <= OP_NONE;
      kind_r   <= MK_ZERO;
      issued_r <= 1'b0;
      start_r  <= 1'b0;
      abort_r  <= 1'b0;
      scans_r  <= 16'h0000;
      cont_r   <= 1'b0;
      mass_r   <= '0;
      pt_r     <= 3'h0;
      settle_r <= 16'h0000;
      max_r    <= 32'h0000_0000;
      push_r   <= 32'h0000_0000;
      pushTp_r <= 1'b0;
      det_r    <= 1'b0;
      nf_r     <= 3'h0;
      rfOn_r   <= 1'b0;
      rfMass_r <= 13'h0000;
    end else begin
      start_r <= 1'b0;
      abort_r <= flush;
      if (cmdWr) begin
        issued_r <= 1'b0;
        op_r     <= cmdOp;
        det_r    <= emSet_r;
        nf_r     <= nfSet_r;
        unique case (cmdOp)
          OP_BAR: begin
            scans_r <= cmdArg;
            cont_r  <= cmdArg == 16'h0000;
            state_r <= S_DRAIN;
          end
          OP_SINGLE: begin
            if (cmdArg == 16'h0000) begin
              rfOn_r  <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              mass_r   <= cmdArg[MASS_W-1:0];
              rfOn_r   <= 1'b1;
              rfMass_r <= 13'(cmdArg) * `BSPM_MASS_SCALE - `BSPM_MINI_HALF;
              settle_r <= 16'h0000;
              state_r  <= S_SETTLE;
            end
          end
          OP_ZERO: state_r <= S_ZERO;
          OP_NONE: state_r <= S_IDLE;
        endcase
      end else begin
        unique case (state_r)
          S_IDLE: ;
          S_DRAIN: begin
            if (fifoEmpty && txIdle)
              state_r <= S_ZERO;
          end
          S_ZERO: begin
            if (!issued_r) begin
              start_r  <= 1'b1;
              kind_r   <= MK_ZERO;
              issued_r <= 1'b1;
            end else if (measDone) begin
              issued_r <= 1'b0;
              state_r  <= S_TUNE;
            end
          end
          S_TUNE: begin
            if (!issued_r) begin
              start_r  <= 1'b1;
              kind_r   <= MK_TUNE;
              issued_r <= 1'b1;
            end else if (measDone) begin
              issued_r <= 1'b0;
              if (op_r == OP_ZERO) begin
                rfOn_r  <= 1'b0;
                state_r <= S_IDLE;
              end else begin
                mass_r   <= init_r;
                rfOn_r   <= 1'b1;
                rfMass_r <= 13'(init_r) * `BSPM_MASS_SCALE;
                state_r  <= (final_r >= init_r) ? S_ION : S_TP;
              end
            end
          end
          S_SETTLE: begin
            // Filter and electrometer settle before the first reading
            if (settle_r == 16'(SETTLE_CYC - 1)) begin
              pt_r    <= 3'h0;
              state_r <= S_ION;
            end else begin
              settle_r <= settle_r + 16'h0001;
            end
          end
          S_ION: begin
            if (!issued_r) begin
              start_r  <= 1'b1;
              kind_r   <= MK_ION;
              issued_r <= 1'b1;
            end else if (measDone) begin
              issued_r <= 1'b0;
              if (op_r == OP_SINGLE) begin
                max_r <= newMax;
                if (pt_r == `BSPM_MINI_LAST) begin
                  push_r   <= newMax;
                  pushTp_r <= 1'b0;
                  state_r  <= S_PUSH;
                end else begin
                  pt_r     <= pt_r + 3'h1;
                  rfMass_r <= rfMass_r + 13'h0001;
                end
              end else begin
                push_r   <= corr;
                pushTp_r <= 1'b0;
                state_r  <= S_PUSH;
              end
            end
          end
          S_TP: begin
            if (det_r || !tpFlag_r) begin
              push_r   <= 32'h0000_0000;
              pushTp_r <= 1'b1;
              state_r  <= S_PUSH;
            end else if (!issued_r) begin
              start_r  <= 1'b1;
              kind_r   <= MK_TP;
              issued_r <= 1'b1;
            end else if (measDone) begin
              issued_r <= 1'b0;
              push_r   <= corr;
              pushTp_r <= 1'b1;
              state_r  <= S_PUSH;
            end
          end
          S_PUSH: begin
            // A full buffer stalls the sequencer, never drops a word
            if (!fifoFull) begin
              if (op_r == OP_SINGLE) begin
                state_r <= S_IDLE;
              end else if (pushTp_r) begin
                if (scanMore) begin
                  if (!cont_r)
                    scans_r <= scans_r - 16'h0001;
                  state_r <= S_ZERO;
                end else begin
                  state_r <= S_IDLE;
                end
              end else if (mass_r == final_r) begin
                state_r <= S_TP;
              end else begin
                mass_r   <= mass_r + 1'b1;
                rfMass_r <= rfMass_r + `BSPM_MASS_SCALE;
                state_r  <= S_ION;
              end
            end
          end
        endcase
      end
    end
  end
endmodule // bspm_seq
`default_nettype wire

// ===== verification/bspm_seq_asserts.sv
// Checker for the bar scan sequencer: measurement order, abort and filter state.
// Assumes it is bound to bspm_seq and sees only that module's ports.
`default_nettype none
module bspm_seq_asserts
  import bspm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  // Engine and outputs
  input wire logic        measStart,
  input wire logic        measAbort,
  input wire bspm_meas_t  measKind,
  input wire logic        measDet,
  input wire logic        rfOn,
  input wire logic        txValid
);
  timeunit 1ns;
  timeprecision 1ns;

  bspm_meas_t lastKind_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // A new command starts no earlier than the cycle after its abort, never in it; a start is still checked first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastKind_r <= MK_TP;
    end else if (measStart) begin
      lastKind_r <= measKind;
    end else if (measAbort) begin
      lastKind_r <= MK_TP;
    end
  end

  sequence s_filter_off_cmd;
    wr && addr == 8'h00 && wdata[17:0] == 18'h2_0000;
  endsequence
  sequence s_zero_tuned;
    wr && addr == 8'h00 && wdata[17:16] == 2'h3 ##[1:60] measStart && measKind == MK_TUNE;
  endsequence

  a_tune_order: assert property (measStart && measKind == MK_TUNE |-> lastKind_r == MK_ZERO)
    else $error("tuning started without a preceding zero");
  a_ion_order: assert property (measStart && measKind == MK_ION |-> lastKind_r != MK_ZERO)
    else $error("ion reading started before tuning");
  a_tp_order: assert property (measStart && measKind == MK_TP |-> lastKind_r inside {MK_ION, MK_TUNE})
    else $error("pressure reading out of place");
  a_tp_multiplier: assert property (measStart && measKind == MK_TP |-> !measDet)
    else $error("pressure measured with multiplier on");
  a_ion_filter: assert property (measStart && measKind == MK_ION |-> rfOn)
    else $error("ion reading with filter off");
  a_abort_cause: assert property (measAbort |-> $past(wr) && $past(addr) == 8'h00)
    else $error("abort without a command write");
  a_abort_flush: assert property (measAbort |-> !txValid)
    else $error("byte still offered after abort");
  a_rf_off: assert property (s_filter_off_cmd |-> ##[1:4] !rfOn)
    else $error("filter not switched off");
  a_zero_off: assert property (s_zero_tuned |-> ##[1:40] !rfOn)
    else $error("filter left on after detector zero");
endmodule // bspm_seq_asserts

bind bspm_seq bspm_seq_asserts chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .measStart(measStart),
  .measAbort(measAbort), .measKind(measKind), .measDet(measDet), .rfOn(rfOn), .txValid(txValid)
);
`default_nettype wire

// ===== verification/bspm_engine_model.sv
// Measurement engine model: answers each start that no abort cancels with a fixed-pattern result.
// Assumes one measurement at a time; a start during a wait restarts it.
`default_nettype none
module bspm_engine_model
  import bspm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Requests
  input wire logic        measStart,
  input wire logic        measAbort,
  input wire bspm_meas_t  measKind,
  input wire logic [12:0] rfMass,
  input wire logic        slow,
  // Results
  output logic            measDone,
  output logic [31:0]     measValue
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0]  waitCnt_r;
  bspm_meas_t  kind_r;
  logic [12:0] mass_r;

  // Peak sits off the centre point so a wrong pick shows
  function automatic logic [31:0] result(input bspm_meas_t k, input logic [12:0] m);
    case (k)
      MK_ZERO: result = 32'hFFFF_FFFD;
      MK_ION:  result = 32'(m) + (32'(m % 13'h000a) << 4);
      MK_TP:   result = 32'h0000_1234;
      default: result = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (measStart) begin
      kind_r <= measKind;
      mass_r <= rfMass;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt_r <= 4'h0;
      measDone <= 1'b0;
      measValue <= 32'h0000_0000;
    end else begin
      measDone <= 1'b0;
      // Result inverted outside the done cycle, so it reads true again every second cycle
      measValue <= ~measValue;
      if (measStart) begin
        waitCnt_r <= slow ? 4'h9 : 4'h2;
      end else if (measAbort) begin
        waitCnt_r <= 4'h0;
      end else if (waitCnt_r == 4'h1) begin
        waitCnt_r <= 4'h0;
        measDone <= 1'b1;
        measValue <= result(kind_r, mass_r);
      end else if (waitCnt_r != 4'h0) begin
        waitCnt_r <= waitCnt_r - 4'h1;
      end
    end
  end
endmodule // bspm_engine_model
`default_nettype wire

// ===== verification/bspm_seq_test.sv
// Testbench of the bar scan sequencer: register port, engine model, byte sink.
// Assumes the engine model's fixed results; the bench acts as host and sink.
`default_nettype none
module bspm_seq_test import bspm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, measStart, measAbort, measDet, measDone, rfOn, txValid, emOn;
  logic        nrst = 1'b0, wr = 1'b0, rd = 1'b0, txReady = 1'b1, slow = 1'b0;
  logic [7:0]  addr = 8'h00, txData;
  logic [31:0] wdata = 32'h0000_0000, rdata, measValue;
  logic [12:0] rfMass;
  logic [2:0]  measNf, noiseFloor;
  bspm_meas_t  measKind;
  int          failures, totalChecks, cycles, starts;
  logic [7:0]  bq[$];
  logic [31:0] words[$];

  bspm_seq #(.SETTLE_CYC(4)) uut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .measStart(measStart), .measAbort(measAbort), .measKind(measKind), .measDet(measDet),
    .measNf(measNf), .measDone(measDone), .measValue(measValue), .rfOn(rfOn), .rfMass(rfMass),
    .emOn(emOn), .noiseFloor(noiseFloor), .txData(txData), .txValid(txValid), .txReady(txReady)
  );
  bspm_engine_model eng (
    .clk(clk), .nrst(nrst), .measStart(measStart), .measAbort(measAbort), .measKind(measKind),
    .rfMass(rfMass), .slow(slow), .measDone(measDone), .measValue(measValue)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Host side: bytes into words, partial bytes and collected words dropped on abort
  always @(posedge clk) begin
    cycles++;
    if (measStart) starts++;
    if (measAbort) begin
      bq.delete();
      words.delete();
    end else if (nrst && txValid && txReady) begin
      bq.push_back(txData);
      if (bq.size() == 4) begin
        words.push_back({bq[3], bq[2], bq[1], bq[0]});
        bq.delete();
      end
    end
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [15:0] arg);
    wr_reg(8'h00, {14'h0000, op, arg});
  endtask

  task automatic get_word(output logic [31:0] w);
    for (int n = 0; n < 3000 && words.size() == 0; n++) @(posedge clk);
    w = (words.size() != 0) ? words.pop_front() : 32'hxxxx_xxxx;
  endtask

  // Offset from the zero step is negative, so each current reads raw plus three
  task automatic scan_words(input int mi, mf, input logic [31:0] tp);
    logic [31:0] w;
    for (int m = mi; m <= mf; m++) begin
      get_word(w);
      check(w, 32'(m * 10 + 3));
    end
    get_word(w);
    check(w, tp);
  endtask

  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h0000_0001;
    for (int n = 0; n < 500 && s[0] !== 1'b0; n++) rd_reg(8'h1c, s);
  endtask

  task automatic t_points;
    logic [31:0] d;
    rd_reg(8'h14, d);
    check(d, 32'h0000_0001);
    wr_reg(8'h04, 32'h0000_0003);
    wr_reg(8'h08, 32'h0000_0003);
    rd_reg(8'h18, d);
    check(d, 32'h0000_0001);
    wr_reg(8'h08, 32'h0000_0002);
    rd_reg(8'h18, d);
    check(d, 32'h0000_0000);
    cmd(2'h1, 16'h0001);
    scan_words(3, 2, 32'h0000_1237);
    wr_reg(8'h08, 32'h0000_0006);
    rd_reg(8'h18, d);
    check(d, 32'h0000_0004);
  endtask

  task automatic t_bar;
    wr_reg(8'h0c, 32'h0000_0002);
    cmd(2'h1, 16'h0001);
    scan_words(3, 6, 32'h0000_1237);
    check(noiseFloor, 3'h2);
    check(measNf, 3'h2);
    repeat (200) @(posedge clk);
    check(words.size(), 0);
  endtask

  task automatic t_detectors;
    logic [31:0] d;
    wr_reg(8'h10, 32'h0000_0001);
    rd_reg(8'h14, d);
    check(d, 32'h0000_0000);
    check(emOn, 1'b1);
    slow <= 1'b1;
    cmd(2'h1, 16'h0001);
    scan_words(3, 6, 32'h0000_0000);
    check(measDet, 1'b1);
    wr_reg(8'h10, 32'h0000_0000);
    cmd(2'h1, 16'h0001);
    scan_words(3, 6, 32'h0000_0000);
    check(measDet, 1'b0);
    wr_reg(8'h14, 32'h0000_0001);
    slow <= 1'b0;
  endtask

  task automatic t_single;
    logic [31:0] w;
    cmd(2'h2, 16'h001c);
    get_word(w);
    check(w, 32'h0000_01aa);
    repeat (4) @(posedge clk);
    check(rfOn, 1'b1);
    check(rfMass, 13'h011b);
    cmd(2'h2, 16'h0000);
    repeat (4) @(posedge clk);
    check(rfOn, 1'b0);
    cmd(2'h2, 16'h001c);
    get_word(w);
    check(w, 32'h0000_01aa);
    cmd(2'h3, 16'h0000);
    wait_idle();
    check(rfOn, 1'b0);
    check(words.size(), 0);
  endtask

  task automatic t_abort;
    wr_reg(8'h08, 32'h0000_0004);
    cmd(2'h1, 16'h0000);
    scan_words(3, 4, 32'h0000_1237);
    cmd(2'h0, 16'h0000);
    wait_idle();
    check(words.size() + bq.size(), 0);
    cmd(2'h1, 16'h0000);
    repeat (2) scan_words(3, 4, 32'h0000_1237);
    cmd(2'h3, 16'h0000);
    wait_idle();
    repeat (20) @(posedge clk);
    check(words.size() + bq.size(), 0);
    check(txValid, 1'b0);
  endtask

  // Sink stalls so the first scan waits whole in the buffer and the transmitter
  task automatic t_pending;
    txReady <= 1'b0;
    cmd(2'h1, 16'h0001);
    wait_idle();
    cmd(2'h1, 16'h0002);
    starts = 0;
    repeat (60) @(posedge clk);
    check(starts, 0);
    txReady <= 1'b1;
    repeat (3) scan_words(3, 4, 32'h0000_1237);
    repeat (200) @(posedge clk);
    check(words.size(), 0);
  endtask

  task automatic print_verdict;
    if (failures == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_points();
    t_bar();
    t_detectors();
    t_single();
    t_abort();
    t_pending();
    print_verdict();
  end
endmodule // bspm_seq_test
`default_nettype wire
